// ### hdl/wpc_pkg.sv
// constants shared by the waveform pattern configuration register block
package wpc_pkg;
    // register offsets on the configuration port
    localparam logic [15:0] ADDR_TW_SHIFT_CFG   = 16'h0047;
    localparam logic [15:0] ADDR_LEAD_WAIT      = 16'h005c;
    localparam logic [15:0] ADDR_FIRST_LOC      = 16'h005d;
    localparam logic [15:0] ADDR_LAST_LOC       = 16'h005e;
    localparam logic [15:0] ADDR_REPEAT_COUNT   = 16'h005f;
    localparam logic [15:0] ADDR_CONFIG_FAULT   = 16'h0060;
    localparam logic [15:0] ADDR_MEM_BASE       = 16'h6000;
    localparam logic [15:0] ADDR_MEM_LAST       = 16'h6fff;

    // reset values
    localparam logic [15:0] RST_TW_SHIFT_CFG    = 16'h0000;
    localparam logic [15:0] RST_LEAD_WAIT       = 16'h0000;
    localparam logic [15:0] RST_FIRST_LOC       = 16'h0000;
    localparam logic [15:0] RST_LAST_LOC        = 16'h0000;
    localparam logic [15:0] RST_REPEAT_COUNT    = 16'h0001;
    localparam logic [5:0]  RST_FAULTS          = 6'h00;

    // field layout
    localparam int LOC_LSB        = 4;     // location field [15:4]
    localparam int SHIFT_W        = 5;     // shift select field [4:0]
    localparam int FAULT_CLEAR    = 15;    // write one to clear all faults
    localparam int F_MEM_CONFLICT = 0;
    localparam int F_ODD_LENGTH   = 1;
    localparam int F_PERIOD_SHORT = 2;
    localparam int F_BEGIN_SMALL  = 3;
    localparam int F_WAIT_SMALL   = 4;
    localparam int F_BEGIN_LARGE  = 5;
    localparam int FAULT_W        = 6;
    localparam int MEM_DATA_LSB   = 2;     // sample in [15:2], [1:0] reserved

    // tuning word assembly
    localparam int               TW_W          = 24;
    localparam int               SAMPLE_W      = 14;
    localparam int               PAD_W         = TW_W - SAMPLE_W;
    localparam logic [4:0]       SHIFT_MAX     = 5'h10;

    // minimum delays and wrap base for short values
    localparam logic [15:0]      WAIT_MIN      = 16'h000e;  // 14
    localparam logic [15:0]      BEGIN_MIN     = 16'h0003;  // 3
    localparam logic [16:0]      WRAP_BASE     = 17'h10000; // 65536

    // delay application state along the run
    typedef enum logic [0:0] {
        WPC_FIRST = 1'b0,
        WPC_LATER = 1'b1
    } wpc_run_state_t;
endpackage

// ### hdl/wpc_regs.sv
// pattern playback configuration registers, fault flags and pattern memory
//
// Summary of operation
// [RULE1] memory tuning word: n register top bits, memory word, zero fill; n above 16 reserved
// [RULE2] playback start location is the 12-bit upper field of the first-location register
// [RULE3] playback stop location is the upper field of the last-location register, reset zero
// [RULE4] sine repeat count is a 16-bit register that resets to one
// [RULE5] writing the top bit of the fault register clears every fault flag
// [RULE6] bit 5 flags an output-begin offset larger than the pattern wait
// [RULE7] bit 4 flags a pattern wait below 14; effective wait wraps to 65536-(14-v)
// [RULE8] bit 3 flags an output-begin below 3; effective offset wraps to 65536-(3-v)
// [RULE9] bit 2 flags a pattern period shorter than the pattern play length
// [RULE10] bit 1 flags an odd played segment length in trigger-delay mode
// [RULE11] bit 0 flags a host memory access colliding with a playback read
// [RULE12] memory words sit at 0x6000-0x6fff, sample top eight bits in [15:8]
// [RULE13] sample low six bits sit in [7:2]; bits [1:0] carry no sample data
// [RULE14] memory tuning enabled combines memory and registers, else registers alone
// [RULE15] tuning word is 24 bits, memory word 14 bits, rest from registers or zeros
// [RULE16] delay-once select applies the lead wait only before the first pattern
// [RULE17] fault flags stay set until cleared by software and reset to zero
`timescale 1ns/1ps
`default_nettype none
module wpc_regs #(
    parameter int MEM_DEPTH = 4096,
    parameter int ADDR_W    = 12
) (
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    // register access from the serial configuration port decoder
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [15:0]         reg_addr_i,
    input  wire logic [15:0]         reg_wdata_i,
    output logic      [15:0]         reg_rdata_o,
    // settings held in other register groups
    input  wire logic                tuning_from_memory_enable_i,
    input  wire logic [23:0]         tuning_word_registers_i,
    input  wire logic                delay_once_select_i,
    input  wire logic [15:0]         out_begin_i,
    input  wire logic [15:0]         pattern_period_i,
    // pattern engine side
    input  wire logic                pat_rd_en_i,
    input  wire logic [ADDR_W-1:0]   pat_rd_addr_i,
    output logic      [13:0]         pat_rd_data_o,
    input  wire logic                run_start_i,
    input  wire logic                pattern_start_i,
    output logic                     apply_lead_wait_o,
    output logic      [23:0]         synth_tuning_word_o,
    output logic      [ADDR_W-1:0]   first_location_o,
    output logic      [ADDR_W-1:0]   last_location_o,
    output logic      [15:0]         lead_wait_o,
    output logic      [15:0]         sine_repeat_count_o,
    output logic      [15:0]         eff_pattern_wait_o,
    output logic      [15:0]         eff_out_begin_o,
    output logic      [5:0]          fault_flags_o
);

    // tuning word from register bits, memory sample and a shift select
    function automatic logic [23:0] tw_assemble(input logic [23:0] regs,
                                                input logic [13:0] sample,
                                                input logic [4:0]  shift);
        logic [23:0] placed;
        logic [23:0] keep;
        placed = {sample, {wpc_pkg::PAD_W{1'b0}}} >> shift;
        keep   = ~({wpc_pkg::TW_W{1'b1}} >> shift);
        return (regs & keep) | placed;
    endfunction

    // short delay values wrap below the 16-bit range
    function automatic logic [15:0] wrap_short(input logic [15:0] v,
                                               input logic [15:0] vmin);
        logic [16:0] t;
        t = wpc_pkg::WRAP_BASE - {1'b0, vmin} + {1'b0, v};
        return t[15:0];
    endfunction

    // address decode for the pattern memory window
    function automatic logic is_mem_addr(input logic [15:0] a);
        return (a >= wpc_pkg::ADDR_MEM_BASE) && (a <= wpc_pkg::ADDR_MEM_LAST);
    endfunction

    logic [13:0] mem [MEM_DEPTH];

    logic [15:0]               tw_shift_cfg_r,   tw_shift_cfg_nxt;
    logic [15:0]               lead_wait_r,      lead_wait_nxt;
    logic [15:0]               first_loc_r,      first_loc_nxt;
    logic [15:0]               last_loc_r,       last_loc_nxt;
    logic [15:0]               repeat_count_r,   repeat_count_nxt;
    logic [5:0]                faults_r,         faults_nxt;
    logic [15:0]               rdata_r,          rdata_nxt;
    logic [13:0]               pat_data_r,       pat_data_nxt;
    logic [23:0]               tw_r,             tw_nxt;
    logic                      apply_r,          apply_nxt;
    logic [15:0]               eff_wait_r,       eff_wait_nxt;
    logic [15:0]               eff_begin_r,      eff_begin_nxt;
    wpc_pkg::wpc_run_state_t   run_state_r,      run_state_nxt;

    logic                      host_mem_wr;
    logic                      host_mem_acc;
    logic [ADDR_W-1:0]         host_mem_idx;
    logic [ADDR_W:0]           play_len;
    logic [5:0]                fault_set;
    logic                      fault_clr;

    // host access into the memory window
    assign host_mem_acc = (reg_wr_i || reg_rd_i) && is_mem_addr(reg_addr_i);   // [RULE12]
    assign host_mem_wr  = reg_wr_i && is_mem_addr(reg_addr_i);
    assign host_mem_idx = reg_addr_i[ADDR_W-1:0];

    // played segment length; a stop before the start gives a wrapped length
    assign play_len = {1'b0, last_loc_r[15:wpc_pkg::LOC_LSB]}
                    - {1'b0, first_loc_r[15:wpc_pkg::LOC_LSB]}
                    + {{ADDR_W{1'b0}}, 1'b1};

    // live fault conditions, caught into sticky flags below
    always_comb begin
        fault_set = '0;
        fault_set[wpc_pkg::F_BEGIN_LARGE]  = out_begin_i > lead_wait_r;          // [RULE6]
        fault_set[wpc_pkg::F_WAIT_SMALL]   = lead_wait_r < wpc_pkg::WAIT_MIN;    // [RULE7]
        fault_set[wpc_pkg::F_BEGIN_SMALL]  = out_begin_i < wpc_pkg::BEGIN_MIN;   // [RULE8]
        fault_set[wpc_pkg::F_PERIOD_SHORT] = {3'h0, play_len} > pattern_period_i; // [RULE9]
        fault_set[wpc_pkg::F_ODD_LENGTH]   = delay_once_select_i && play_len[0]; // [RULE10]
        fault_set[wpc_pkg::F_MEM_CONFLICT] = host_mem_acc && pat_rd_en_i;        // [RULE11]
    end

    assign fault_clr = reg_wr_i && (reg_addr_i == wpc_pkg::ADDR_CONFIG_FAULT)
                     && reg_wdata_i[wpc_pkg::FAULT_CLEAR];                       // [RULE5]

    // configuration registers written from the port; reserved bits are kept as written
    always_comb begin
        tw_shift_cfg_nxt = tw_shift_cfg_r;
        lead_wait_nxt    = lead_wait_r;
        first_loc_nxt    = first_loc_r;
        last_loc_nxt     = last_loc_r;
        repeat_count_nxt = repeat_count_r;
        if (reg_wr_i) begin
            case (reg_addr_i)
                wpc_pkg::ADDR_TW_SHIFT_CFG: tw_shift_cfg_nxt = reg_wdata_i;
                wpc_pkg::ADDR_LEAD_WAIT:    lead_wait_nxt    = reg_wdata_i;
                wpc_pkg::ADDR_FIRST_LOC:    first_loc_nxt    = reg_wdata_i;   // [RULE2]
                wpc_pkg::ADDR_LAST_LOC:     last_loc_nxt     = reg_wdata_i;   // [RULE3]
                wpc_pkg::ADDR_REPEAT_COUNT: repeat_count_nxt = reg_wdata_i;   // [RULE4]
                default: ;
            endcase
        end
    end

    // configuration registers, reset to their documented values
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tw_shift_cfg_r <= wpc_pkg::RST_TW_SHIFT_CFG;
            lead_wait_r    <= wpc_pkg::RST_LEAD_WAIT;
            first_loc_r    <= wpc_pkg::RST_FIRST_LOC;
            last_loc_r     <= wpc_pkg::RST_LAST_LOC;
            repeat_count_r <= wpc_pkg::RST_REPEAT_COUNT;
        end else begin
            tw_shift_cfg_r <= tw_shift_cfg_nxt;
            lead_wait_r    <= lead_wait_nxt;
            first_loc_r    <= first_loc_nxt;
            last_loc_r     <= last_loc_nxt;
            repeat_count_r <= repeat_count_nxt;
        end
    end

    // read data holds until the next read; unmapped reads give zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd_i) begin
            case (reg_addr_i)
                wpc_pkg::ADDR_TW_SHIFT_CFG: rdata_nxt = tw_shift_cfg_r;
                wpc_pkg::ADDR_LEAD_WAIT:    rdata_nxt = lead_wait_r;
                wpc_pkg::ADDR_FIRST_LOC:    rdata_nxt = first_loc_r;
                wpc_pkg::ADDR_LAST_LOC:     rdata_nxt = last_loc_r;
                wpc_pkg::ADDR_REPEAT_COUNT: rdata_nxt = repeat_count_r;
                wpc_pkg::ADDR_CONFIG_FAULT: rdata_nxt = {10'h000, faults_r};  // clear bit reads 0
                default: begin
                    if (is_mem_addr(reg_addr_i)) begin
                        rdata_nxt = {mem[host_mem_idx], 2'b00};                // [RULE13]
                    end else begin
                        rdata_nxt = '0;
                    end
                end
            endcase
        end
    end

    // read data register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // sticky faults; a condition present in the clearing cycle survives
    always_comb begin
        faults_nxt = (fault_clr ? wpc_pkg::RST_FAULTS : faults_r) | fault_set;  // [RULE17]
    end

    // fault flags, all clear after reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            faults_r <= wpc_pkg::RST_FAULTS;
        end else begin
            faults_r <= faults_nxt;
        end
    end

    // playback read and tuning word source
    always_comb begin
        pat_data_nxt = pat_data_r;
        tw_nxt       = tuning_word_registers_i;
        // the engine sees the old word when the host writes the same location
        if (pat_rd_en_i) begin
            pat_data_nxt = mem[pat_rd_addr_i];
        end
        // reserved shift values fall back to the registers alone
        if (tuning_from_memory_enable_i &&
            (tw_shift_cfg_r[wpc_pkg::SHIFT_W-1:0] <= wpc_pkg::SHIFT_MAX)) begin  // [RULE14]
            tw_nxt = tw_assemble(tuning_word_registers_i, pat_data_r,
                                 tw_shift_cfg_r[wpc_pkg::SHIFT_W-1:0]);           // [RULE1] [RULE15]
        end
    end

    // playback sample and tuning word registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pat_data_r <= '0;
            tw_r       <= '0;
        end else begin
            pat_data_r <= pat_data_nxt;
            tw_r       <= tw_nxt;
        end
    end

    // effective delays; registered so the pattern engine never sees a glitching value
    always_comb begin
        eff_wait_nxt  = lead_wait_r;
        eff_begin_nxt = out_begin_i;
        if (fault_set[wpc_pkg::F_WAIT_SMALL]) begin
            eff_wait_nxt = wrap_short(lead_wait_r, wpc_pkg::WAIT_MIN);        // [RULE7]
        end
        if (fault_set[wpc_pkg::F_BEGIN_SMALL]) begin
            eff_begin_nxt = wrap_short(out_begin_i, wpc_pkg::BEGIN_MIN);      // [RULE8]
        end
    end

    // effective delay registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            eff_wait_r  <= '0;
            eff_begin_r <= '0;
        end else begin
            eff_wait_r  <= eff_wait_nxt;
            eff_begin_r <= eff_begin_nxt;
        end
    end

    // lead wait before each pattern, or only the first of a run
    always_comb begin
        run_state_nxt = run_state_r;
        apply_nxt     = 1'b0;
        case (run_state_r)
            wpc_pkg::WPC_FIRST: begin
                if (pattern_start_i) begin
                    apply_nxt     = 1'b1;
                    run_state_nxt = wpc_pkg::WPC_LATER;
                end
            end
            wpc_pkg::WPC_LATER: begin
                if (pattern_start_i) begin
                    apply_nxt = !delay_once_select_i;                         // [RULE16]
                end
            end
            default: run_state_nxt = wpc_pkg::WPC_FIRST;
        endcase
        // a new run re-arms the first pattern; a start in the same cycle is judged by the old state
        if (run_start_i) begin
            run_state_nxt = wpc_pkg::WPC_FIRST;
        end
    end

    // run state and lead wait pulse
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            apply_r     <= 1'b0;
            run_state_r <= wpc_pkg::WPC_FIRST;
        end else begin
            apply_r     <= apply_nxt;
            run_state_r <= run_state_nxt;
        end
    end

    // memory has no reset; its contents are undefined until loaded
    always_ff @(posedge clk_i) begin
        if (host_mem_wr) begin
            mem[host_mem_idx] <= reg_wdata_i[15:wpc_pkg::MEM_DATA_LSB];       // [RULE12] [RULE13]
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata_o         = rdata_r;
    assign pat_rd_data_o       = pat_data_r;
    assign synth_tuning_word_o = tw_r;
    assign apply_lead_wait_o   = apply_r;
    assign first_location_o    = first_loc_r[15:wpc_pkg::LOC_LSB];
    assign last_location_o     = last_loc_r[15:wpc_pkg::LOC_LSB];
    assign lead_wait_o         = lead_wait_r;
    assign sine_repeat_count_o = repeat_count_r;
    assign fault_flags_o       = faults_r;
    assign eff_pattern_wait_o  = eff_wait_r;
    assign eff_out_begin_o     = eff_begin_r;

endmodule
`default_nettype wire

// ### verif/wpc_regs_checker.sv
// concurrent checks on the configuration register block ports
`timescale 1ns/1ps
`default_nettype none
module wpc_regs_checker #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [15:0]       reg_addr_i,
    input  wire logic [15:0]       reg_wdata_i,
    input  wire logic              tuning_from_memory_enable_i,
    input  wire logic [23:0]       tuning_word_registers_i,
    input  wire logic              delay_once_select_i,
    input  wire logic [15:0]       out_begin_i,
    input  wire logic              pat_rd_en_i,
    input  wire logic              pattern_start_i,
    input  wire logic              apply_lead_wait_o,
    input  wire logic [23:0]       synth_tuning_word_o,
    input  wire logic [ADDR_W-1:0] first_location_o,
    input  wire logic [15:0]       lead_wait_o,
    input  wire logic [15:0]       sine_repeat_count_o,
    input  wire logic [15:0]       eff_pattern_wait_o,
    input  wire logic [15:0]       eff_out_begin_o,
    input  wire logic [5:0]        fault_flags_o
);
    default clocking @(posedge clk_i); endclocking
    // checks start one edge after release, once the flops have left reset
    logic armed_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= 1'b1;
        end
    end
    default disable iff (!reset_n_i || !armed_r);
    // the clear strobe is the only event allowed to drop a flag
    logic clr_w;
    assign clr_w = reg_wr_i && reg_addr_i == 16'h0060 && reg_wdata_i[15];

    first_loc_a: assert property (
        reg_wr_i && reg_addr_i == 16'h005d |=> first_location_o == $past(reg_wdata_i[15:4]))
        else $error("first location not taken from write");
    repeat_cnt_a: assert property (
        reg_wr_i && reg_addr_i == 16'h005f |=> sine_repeat_count_o == $past(reg_wdata_i))
        else $error("sine repeat count not taken from write");
    wait_wrap_a: assert property (
        lead_wait_o < 16'h000e |=> eff_pattern_wait_o == 16'hfff2 + $past(lead_wait_o)
        && fault_flags_o[4]) else $error("short lead wait not wrapped or flagged");
    begin_wrap_a: assert property (
        out_begin_i < 16'h0003 |=> eff_out_begin_o == 16'hfffd + $past(out_begin_i)
        && fault_flags_o[3]) else $error("short output begin not wrapped or flagged");
    begin_large_a: assert property (
        out_begin_i > lead_wait_o |=> fault_flags_o[5]) else $error("large begin not flagged");
    mem_conflict_a: assert property (
        pat_rd_en_i && (reg_wr_i || reg_rd_i) && reg_addr_i[15:12] == 4'h6 |=> fault_flags_o[0])
        else $error("memory conflict not flagged");
    flag_sticky_a: assert property (
        !clr_w |=> (fault_flags_o & $past(fault_flags_o)) == $past(fault_flags_o))
        else $error("fault flag dropped without clear");
    flag_clear_a: assert property (
        clr_w && out_begin_i >= 16'h0003 && lead_wait_o >= 16'h000e && !pat_rd_en_i
        && out_begin_i <= lead_wait_o |=> fault_flags_o[5:3] == 3'b000 && !fault_flags_o[0])
        else $error("clear did not drop flags");
    tw_regs_a: assert property (
        !tuning_from_memory_enable_i |=> synth_tuning_word_o == $past(tuning_word_registers_i))
        else $error("tuning word not from registers");
    lead_pulse_a: assert property (
        pattern_start_i && !delay_once_select_i |=> apply_lead_wait_o)
        else $error("lead wait not applied");
endmodule
bind wpc_regs wpc_regs_checker #(.ADDR_W(ADDR_W)) wpc_regs_checker_i (.*);
`default_nettype wire

// ### verif/wpc_host_model.sv
// configuration master driving the parallel register port
`timescale 1ns/1ps
`default_nettype none
module wpc_host_model (
    input  wire logic        clk_i,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic      [15:0] reg_addr_o,
    output logic      [15:0] reg_wdata_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 16'h0000;
        reg_wdata_o = 16'h0000;
    end
    // one access held for a single edge; released lines are scrambled, not left stale
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_o <= wr;
        reg_rd_o <= !wr;
        reg_addr_o <= a;
        reg_wdata_o <= d;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the pattern configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_i, reset_n_i, reg_wr_i, reg_rd_i, tuning_from_memory_enable_i;
    logic        delay_once_select_i, pat_rd_en_i, run_start_i, pattern_start_i;
    logic        apply_lead_wait_o, rd_d;
    logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, out_begin_i, pattern_period_i;
    logic [15:0] lead_wait_o, sine_repeat_count_o, eff_pattern_wait_o, eff_out_begin_o;
    logic [23:0] tuning_word_registers_i, synth_tuning_word_o;
    logic [11:0] pat_rd_addr_i, first_location_o, last_location_o;
    logic [13:0] pat_rd_data_o;
    logic [5:0]  fault_flags_o;
    logic [15:0] exp_q[$];
    logic [15:0] ra[5] = '{16'h005c, 16'h005d, 16'h005e, 16'h005f, 16'h0047};
    int          bad_count = 0;
    int          n_compared = 0;

    wpc_regs wpc_regs_i (.*);
    wpc_host_model wpc_host_model_i (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

    always #5 clk_i = ~clk_i;

    task automatic end_of_test;
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        wpc_host_model_i.acc(1'b1, a, d);
    endtask
    // reads only note the expectation; the watcher below compares
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        wpc_host_model_i.acc(1'b0, a, 16'h0000);
    endtask
    task automatic pst(input logic e);
        @(posedge clk_i) pattern_start_i <= 1'b1;
        @(posedge clk_i) pattern_start_i <= 1'b0;
        @(negedge clk_i) chk("lead_pulse", {23'h0, e}, {23'h0, apply_lead_wait_o});
    endtask

    // read data lands one edge after the strobe; compare mid-cycle
    always @(posedge clk_i) rd_d <= reg_rd_i;
    always @(negedge clk_i) if (rd_d === 1'b1)
        chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata_o});

    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        end_of_test();
    end

    initial begin
        logic [15:0] d;
        logic [11:0] a;
        logic [23:0] tw;
        clk_i = 1'b0;
        reset_n_i = 1'b0;
        {tuning_from_memory_enable_i, delay_once_select_i, pat_rd_en_i} = 3'b000;
        {run_start_i, pattern_start_i, pat_rd_addr_i} = 14'h0000;
        tuning_word_registers_i = 24'h000000;
        out_begin_i = 16'h0005;
        pattern_period_i = 16'h0100;
        d = 16'($urandom(32'h23c77806));
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(16'h005f, 16'h0001);
        rd(16'h005e, 16'h0000);
        rd(16'h0060, 16'h0030);
        foreach (ra[i]) begin
            d = 16'($urandom());
            wr(ra[i], d);
            rd(ra[i], d);
        end
        wr(16'h0050, 16'hffff);
        rd(16'h0050, 16'h0000);
        // even 16-word segment, trigger-delay mode, then break one condition at a time
        wr(16'h005c, 16'h0100);
        wr(16'h005d, 16'h0100);
        wr(16'h005e, 16'h01f0);
        delay_once_select_i <= 1'b1;
        wr(16'h0060, 16'h8000);
        rd(16'h0060, 16'h0000);
        wr(16'h005e, 16'h01e0);
        rd(16'h0060, 16'h0002);
        wr(16'h005e, 16'h01f0);
        @(negedge clk_i);
        chk("last_loc", 24'h00001f, {12'h000, last_location_o});
        chk("lead_wait", 24'h000100, {8'h00, lead_wait_o});
        rd(16'h0060, 16'h0002);
        pattern_period_i <= 16'h000f;
        rd(16'h0060, 16'h0006);
        pattern_period_i <= 16'h0100;
        out_begin_i <= 16'h0001;
        rd(16'h0060, 16'h000e);
        chk("eff_begin", 24'h00fffe, {8'h00, eff_out_begin_o});
        out_begin_i <= 16'h0200;
        rd(16'h0060, 16'h002e);
        wr(16'h005c, 16'h0005);
        rd(16'h0060, 16'h003e);
        chk("eff_wait", 24'h00fff7, {8'h00, eff_pattern_wait_o});
        out_begin_i <= 16'h0005;
        wr(16'h005c, 16'h0100);
        wr(16'h0060, 16'h8000);
        rd(16'h0060, 16'h0000);
        // one memory word, then a host read colliding with playback
        a = 12'($urandom());
        d = 16'($urandom());
        wr({4'h6, a}, d);
        rd({4'h6, a}, {d[15:2], 2'b00});
        pat_rd_addr_i <= a;
        pat_rd_en_i <= 1'b1;
        rd({4'h6, a}, {d[15:2], 2'b00});
        @(negedge clk_i);
        chk("pat_data", {10'h0, d[15:2]}, {10'h0, pat_rd_data_o});
        rd(16'h0060, 16'h0001);
        tw = 24'($urandom());
        tuning_word_registers_i <= tw;
        tuning_from_memory_enable_i <= 1'b1;
        for (int n = 0; n <= 17; n++) begin
            wr(16'h0047, 16'(n));
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            chk("tuning", (n > 16) ? tw : ((tw & ~(24'hffffff >> n)) | ({d[15:2], 10'h000} >> n)),
                synth_tuning_word_o);
        end
        @(posedge clk_i) tuning_from_memory_enable_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("tuning_regs", tw, synth_tuning_word_o);
        pst(1'b1);
        pst(1'b0);
        @(posedge clk_i) delay_once_select_i <= 1'b0;
        pst(1'b1);
        @(posedge clk_i) delay_once_select_i <= 1'b1;
        @(posedge clk_i) run_start_i <= 1'b1;
        @(posedge clk_i) run_start_i <= 1'b0;
        pst(1'b1);
        repeat (3) @(posedge clk_i);
        end_of_test();
    end
endmodule
`default_nettype wire
